/* core/pomf_output_stage.sv */
// Purpose: final pwm output stage: software mask, fault brake, per-channel polarity
// Assumes: generator waveform and adc compare event are on ref_clk_i; fault pin is async
// Notes:   registers reached over classic wishbone; pin levels are registered
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - mask enable substitutes mask level for waveform
// - mask level bit chooses forced low/high
// - mask enables reset to zero
// - masked level still passes polarity inversion
// - fault pin acts only when enabled
// - fault forces channels 0-5 to data
// - channels 6,7 hold level at fault
// - fault clears generator run bit
// - fault resets period counter to zero
// - fault sets flag, requests fault interrupt
// - flag cleared by software, brake persists
// - setting run bit releases fault brake
// - edge select chooses falling or rising
// - fault pin filtered over eight clocks
// - adc compare event acts as fault
// - invert bit complements channel pin output
// - invert bits reset to zero
// - run bit is control-first bit seven
module pomf_output_stage (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_i,
   input  wire pomf_pkg::pomf_wb_req_s wb_req_i,
   output pomf_pkg::pomf_wb_rsp_s     wb_rsp_o,
   input  wire logic [7:0]            gen_wave_i,
   input  wire logic                  fault_input_pin_i,
   input  wire logic                  adc_cmp_event_i,
   output logic [7:0]                 pwm_pin_o,
   output logic                       generator_run_o,
   output logic                       counter_clear_o,
   output logic                       fault_irq_req_o,
   output logic [7:0]                 pwm_control_second_o
);

   localparam int NCH = pomf_pkg::NUM_CH;
   localparam int FCH = pomf_pkg::FAULT_CH;

   logic [7:0]  invert_ff;
   logic [7:0]  fault_data_ff;
   logic [7:0]  ctrl_second_ff;
   logic [7:0]  mask_en_ff;
   logic [7:0]  mask_lvl_ff;
   logic        run_ff;
   logic        brake_ff;
   logic [7:0]  pin_ff;
   logic [1:0]  hold_ff;
   logic        cnt_clear_ff;
   logic        ack_ff;
   logic [31:0] rdat_ff;
   logic        sync1_ff;
   logic        sync2_ff;
   logic        filt_ff;
   logic [3:0]  stable_cnt_ff;

   logic        req;
   logic        adr_hi_zero;
   logic [7:0]  idx;
   logic        wr_commit;
   logic        wr_invert;
   logic        wr_fault;
   logic        wr_first;
   logic        wr_second;
   logic        wr_mask_en;
   logic        wr_mask_lvl;
   logic [7:0]  wdat;
   logic [31:0] nxt_rdat;
   logic        pin_edge;
   logic        fault_event;
   logic        brake_act;
   logic [7:0]  chan_norm;
   logic [7:0]  chan_sel;
   logic [7:0]  nxt_pin;

   // ------------------------------------------------------------ wishbone slave
   assign req         = wb_req_i.cyc & wb_req_i.stb;
   assign idx         = wb_req_i.adr[9:2];
   assign adr_hi_zero = (wb_req_i.adr[pomf_pkg::ADR_W-1:10] == 2'h0)
                        && (wb_req_i.adr[1:0] == 2'h0);
   assign wdat        = wb_req_i.dat[7:0];
   // write lands on the edge where the master sees ack
   assign wr_commit   = req & ack_ff & wb_req_i.we & wb_req_i.sel[0] & adr_hi_zero;
   assign wr_invert   = wr_commit && (idx == pomf_pkg::IDX_OUTPUT_INVERT);
   assign wr_fault    = wr_commit && (idx == pomf_pkg::IDX_FAULT_DATA);
   assign wr_first    = wr_commit && (idx == pomf_pkg::IDX_CTRL_FIRST);
   assign wr_second   = wr_commit && (idx == pomf_pkg::IDX_CTRL_SECOND);
   assign wr_mask_en  = wr_commit && (idx == pomf_pkg::IDX_MASK_ENABLE);
   assign wr_mask_lvl = wr_commit && (idx == pomf_pkg::IDX_MASK_LEVEL);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_comb begin
      nxt_rdat = 32'h0000_0000;
      if (adr_hi_zero) begin
         unique case (idx)
            pomf_pkg::IDX_OUTPUT_INVERT: nxt_rdat[7:0] = invert_ff;
            pomf_pkg::IDX_FAULT_DATA:    nxt_rdat[7:0] = fault_data_ff;
            pomf_pkg::IDX_CTRL_FIRST:    nxt_rdat[pomf_pkg::POS_GENERATOR_RUN] = run_ff;
            pomf_pkg::IDX_CTRL_SECOND:   nxt_rdat[7:0] = ctrl_second_ff;
            pomf_pkg::IDX_MASK_ENABLE:   nxt_rdat[7:0] = mask_en_ff;
            pomf_pkg::IDX_MASK_LEVEL:    nxt_rdat[7:0] = mask_lvl_ff;
            default:                     nxt_rdat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdat_ff <= 32'h0000_0000;
      end else if (req & ~ack_ff) begin
         rdat_ff <= nxt_rdat;
      end
   end

   // one driver for the whole response struct
   assign wb_rsp_o = '{ack: ack_ff, dat: rdat_ff};

   // ------------------------------------------------------------ plain registers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         invert_ff <= pomf_pkg::RST_OUTPUT_INVERT;
      end else if (wr_invert) begin
         invert_ff <= wdat;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mask_en_ff  <= pomf_pkg::RST_MASK_ENABLE;
         mask_lvl_ff <= pomf_pkg::RST_MASK_LEVEL;
      end else begin
         if (wr_mask_en) begin
            mask_en_ff <= wdat;
         end
         if (wr_mask_lvl) begin
            mask_lvl_ff <= wdat;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl_second_ff <= pomf_pkg::RST_CTRL_SECOND;
      end else if (wr_second) begin
         ctrl_second_ff <= wdat;
      end
   end

   assign pwm_control_second_o = ctrl_second_ff;

   // ------------------------------------------------------------ fault pin filter
   // first stage feeds only the second stage
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= fault_input_pin_i;
         sync2_ff <= sync1_ff;
      end
   end

   // new level must persist the whole window; shorter glitches are dropped
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         filt_ff       <= 1'b0;
         stable_cnt_ff <= 4'h0;
      end else if (sync2_ff == filt_ff) begin
         stable_cnt_ff <= 4'h0;
      end else if (stable_cnt_ff == pomf_pkg::DEBOUNCE_LAST) begin
         filt_ff       <= sync2_ff;
         stable_cnt_ff <= 4'h0;
      end else begin
         stable_cnt_ff <= stable_cnt_ff + 4'h1;
      end
   end

   // edge of the filtered level in the chosen direction
   assign pin_edge = (sync2_ff != filt_ff)
                     && (stable_cnt_ff == pomf_pkg::DEBOUNCE_LAST)
                     && (sync2_ff == fault_data_ff[pomf_pkg::POS_FAULT_EDGE_SEL])
                     && ctrl_second_ff[pomf_pkg::POS_FAULT_PIN_ENABLE];

   assign fault_event = pin_edge | adc_cmp_event_i;

   // ------------------------------------------------------------ fault / run state
   // a fault in the same cycle as a run write wins, so the brake is never missed
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         run_ff <= pomf_pkg::RST_GEN_RUN;
      end else if (fault_event) begin
         run_ff <= 1'b0;
      end else if (wr_first) begin
         run_ff <= wdat[pomf_pkg::POS_GENERATOR_RUN];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         brake_ff <= 1'b0;
      end else if (fault_event) begin
         brake_ff <= 1'b1;
      end else if (wr_first && wdat[pomf_pkg::POS_GENERATOR_RUN]) begin
         brake_ff <= 1'b0;
      end
   end

   // flag: set wins over clear; clearing leaves the brake untouched
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fault_data_ff <= pomf_pkg::RST_FAULT_DATA;
      end else begin
         if (wr_fault) begin
            fault_data_ff[6:0] <= wdat[6:0];
         end
         if (fault_event) begin
            fault_data_ff[pomf_pkg::POS_FAULT_FLAG] <= 1'b1;
         end else if (wr_fault && !wdat[pomf_pkg::POS_FAULT_FLAG]) begin
            fault_data_ff[pomf_pkg::POS_FAULT_FLAG] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_clear_ff <= 1'b0;
      end else begin
         cnt_clear_ff <= fault_event;
      end
   end

   assign generator_run_o = run_ff;
   assign counter_clear_o = cnt_clear_ff;
   assign fault_irq_req_o = fault_data_ff[pomf_pkg::POS_FAULT_FLAG];

   // ------------------------------------------------------------ channel path
   assign brake_act = brake_ff | fault_event;

   // upper channels freeze their pre-polarity level at the fault moment
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         hold_ff <= 2'h0;
      end else if (fault_event && !brake_ff) begin
         hold_ff <= chan_norm[NCH-1:FCH];
      end
   end

   genvar n;
   generate
      for (n = 0; n < NCH; n++) begin : g_ch
         assign chan_norm[n] = mask_en_ff[n] ? mask_lvl_ff[n]
                                             : gen_wave_i[n];
         if (n < FCH) begin : g_fault
            assign chan_sel[n] = brake_act ? fault_data_ff[n] : chan_norm[n];
         end else begin : g_hold
            assign chan_sel[n] = !brake_act ? chan_norm[n]
                               : brake_ff  ? hold_ff[n-FCH]
                                           : chan_norm[n];
         end
      end
   endgenerate

   // polarity applied last, so forced and masked levels invert too
   assign nxt_pin = chan_sel ^ invert_ff;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_ff <= 8'h00;
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   assign pwm_pin_o = pin_ff;

   // ------------------------------------------------------------ checks
   sequence s_fault_hit;
      fault_event;
   endsequence

   sequence s_brake_entered;
      brake_ff && !run_ff && cnt_clear_ff && fault_data_ff[pomf_pkg::POS_FAULT_FLAG];
   endsequence

   a_mask_forces_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!brake_act && mask_en_ff[0])
      |=> pin_ff[0] == ($past(mask_lvl_ff[0]) ^ $past(invert_ff[0])))
      else $error("masked channel 0 pin wrong");

   a_gen_passes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!brake_act && !mask_en_ff[3])
      |=> pin_ff[3] == ($past(gen_wave_i[3]) ^ $past(invert_ff[3])))
      else $error("unmasked channel 3 does not follow waveform");

   a_reset_clears_cfg: assert property (@(posedge ref_clk_i)
      rst_i |=> (mask_en_ff == 8'h00) && (invert_ff == 8'h00) && !run_ff)
      else $error("mask or invert not zero after reset");

   a_pin_gate_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!ctrl_second_ff[pomf_pkg::POS_FAULT_PIN_ENABLE] && !adc_cmp_event_i && !brake_ff)
      |=> !brake_ff)
      else $error("fault pin acted while disabled");

   a_brake_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_fault_hit |=> s_brake_entered)
      else $error("fault did not stop run, clear counter and set flag");

   a_fault_data_out: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_fault_hit ##1 (brake_ff && !wr_first)[*2]
      |-> pin_ff[5:0] == ($past(fault_data_ff[5:0]) ^ $past(invert_ff[5:0])))
      else $error("channels 0-5 not forced to fault data");

   a_upper_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (brake_ff && !wr_first && !$past(wr_invert)) |=> $stable(pin_ff[7:6]))
      else $error("channels 6/7 moved during brake");

   a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (fault_data_ff[pomf_pkg::POS_FAULT_FLAG] && !wr_fault)
      |=> fault_data_ff[pomf_pkg::POS_FAULT_FLAG])
      else $error("fault flag dropped without software");

   a_brake_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (brake_ff && wr_first && wdat[pomf_pkg::POS_GENERATOR_RUN] && !fault_event)
      |=> !brake_ff && run_ff)
      else $error("run write did not release brake");

   a_flag_clear_keeps: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (brake_ff && wr_fault && !wr_first) |=> brake_ff)
      else $error("flag clear released brake");

   a_debounce_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $changed(filt_ff) |-> $past(sync2_ff != filt_ff, 8) && $past(sync2_ff != filt_ff, 1))
      else $error("filtered fault level changed too soon");

   a_edge_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pin_edge |=> filt_ff == $past(fault_data_ff[pomf_pkg::POS_FAULT_EDGE_SEL]))
      else $error("fault edge in wrong direction");

endmodule : pomf_output_stage

`default_nettype wire

/* shared/pomf_pkg.sv */
// Purpose: shared constants and carrier types for the pwm output mask/fault/polarity stage
// Assumes: classic wishbone, 32-bit data, one aligned word per register
// Notes:   byte address of a register is four times its index
package pomf_pkg;

   localparam int NUM_CH   = 8;
   localparam int FAULT_CH = 6;
   localparam int ADR_W    = 12;
   localparam int DAT_W    = 32;
   localparam int REG_W    = 8;

   // register indices; byte address = 4 * index
   localparam logic [7:0] IDX_OUTPUT_INVERT = 8'hd6;
   localparam logic [7:0] IDX_FAULT_DATA    = 8'hd7;
   localparam logic [7:0] IDX_CTRL_FIRST    = 8'hd8;
   localparam logic [7:0] IDX_CTRL_SECOND   = 8'hdf;
   localparam logic [7:0] IDX_MASK_ENABLE   = 8'hfb;
   localparam logic [7:0] IDX_MASK_LEVEL    = 8'hfc;

   // field positions
   localparam int POS_GENERATOR_RUN    = 7;
   localparam int POS_FAULT_PIN_ENABLE = 3;
   localparam int POS_FAULT_FLAG       = 7;
   localparam int POS_FAULT_EDGE_SEL   = 6;

   // reset values
   localparam logic [7:0] RST_OUTPUT_INVERT = 8'h00;
   localparam logic [7:0] RST_FAULT_DATA    = 8'h00;
   localparam logic [7:0] RST_CTRL_SECOND   = 8'h00;
   localparam logic [7:0] RST_MASK_ENABLE   = 8'h00;
   localparam logic [7:0] RST_MASK_LEVEL    = 8'h00;
   localparam logic       RST_GEN_RUN       = 1'b0;

   // fault pin filter length in system clock periods
   localparam int         DEBOUNCE_CYC = 8;
   localparam logic [3:0] DEBOUNCE_LAST = 4'(DEBOUNCE_CYC - 1);

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [3:0]       sel;
      logic [DAT_W-1:0] dat;
   } pomf_wb_req_s;

   typedef struct packed {
      logic             ack;
      logic [DAT_W-1:0] dat;
   } pomf_wb_rsp_s;

endpackage : pomf_pkg

/* tb/pomf_fault_src.sv */
// Purpose: external fault sensing source driving the fault pin
// Assumes: driven from the bench just after a rising clock edge
// Notes:   the pin is always driven, idle level is the inverse of the active one
`timescale 1ns/100ps
`default_nettype none

module pomf_fault_src (
   input  wire logic ref_clk_i,
   output logic      fault_pin_o
);
   initial fault_pin_o = 1'b0;

   // held long enough for the pin filter to take the new level
   task automatic set_idle(input logic lvl);
      fault_pin_o <= lvl;
      repeat (12) @(posedge ref_clk_i);
   endtask : set_idle

   // active level held for len clocks, then back to idle
   task automatic pulse(input logic act, input int len);
      fault_pin_o <= act;
      repeat (len) @(posedge ref_clk_i);
      fault_pin_o <= ~act;
      @(posedge ref_clk_i);
   endtask : pulse
endmodule : pomf_fault_src

`default_nettype wire

/* tb/tb_pwm_output_mask_fault_polarity.sv */
// Purpose: self-checking bench for the pwm output mask/fault/polarity stage
// Assumes: classic wishbone, ack one cycle after the request is taken
// Notes:   pin checks wait a few clocks for the registered output to land
`timescale 1ns/100ps
`default_nettype none

module tb_pwm_output_mask_fault_polarity;
   localparam logic [11:0] A_INV = 12'h358;
   localparam logic [11:0] A_FD  = 12'h35c;
   localparam logic [11:0] A_C1  = 12'h360;
   localparam logic [11:0] A_C2  = 12'h37c;
   localparam logic [11:0] A_MEN = 12'h3ec;
   localparam logic [11:0] A_MLV = 12'h3f0;

   logic                   ref_clk_i;
   logic                   rst_i;
   pomf_pkg::pomf_wb_req_s req;
   pomf_pkg::pomf_wb_rsp_s rsp;
   logic [7:0]             gen_wave;
   logic                   adc_evt;
   wire logic              fpin;
   logic [7:0]             pins;
   logic                   run;
   logic                   clr;
   logic                   irq;
   logic [7:0]             ctl2;
   logic [7:0]             r;
   int                     num_errors;
   int                     n_tests;
   int                     n_clr;

   pomf_output_stage dut_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .gen_wave_i(gen_wave), .fault_input_pin_i(fpin), .adc_cmp_event_i(adc_evt),
      .pwm_pin_o(pins), .generator_run_o(run), .counter_clear_o(clr),
      .fault_irq_req_o(irq), .pwm_control_second_o(ctl2)
   );

   pomf_fault_src src_u (.ref_clk_i(ref_clk_i), .fault_pin_o(fpin));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   initial n_clr = 0;
   always @(posedge ref_clk_i) begin
      if (clr === 1'b1) n_clr++;
   end

   task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] wd,
                     output logic [7:0] rd);
      req.cyc <= 1'b1;
      req.stb <= 1'b1;
      req.we  <= we;
      req.adr <= adr;
      req.sel <= 4'hf;
      req.dat <= {24'h000000, wd};
      // no local limit: the watchdog ends a hung transfer
      do begin
         @(posedge ref_clk_i);
      end while (rsp.ack !== 1'b1);
      rd = rsp.dat[7:0];
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      req.we  <= 1'b0;
      @(posedge ref_clk_i);
   endtask : wb

   task automatic wr(input logic [11:0] adr, input logic [7:0] wd);
      logic [7:0] d;
      wb(1'b1, adr, wd, d);
   endtask : wr

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : idle

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial begin
      logic [11:0] adrs [7];
      adrs = '{A_INV, A_FD, A_C1, A_C2, A_MEN, A_MLV, 12'h004};
      num_errors = 0;
      n_tests = 0;
      rst_i = 1'b1;
      req = '0;
      gen_wave = 8'hbc;
      adc_evt = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      // reset values, the last entry is unmapped and reads zero
      foreach (adrs[i]) begin
         wb(1'b0, adrs[i], 8'h00, r);
         chk(r, 8'h00, "reset value");
      end
      idle(3);
      chk(pins, 8'hbc, "pass-through");
      $display("test reset values done");
      wr(A_MEN, 8'h0f);
      wr(A_MLV, 8'h05);
      idle(3);
      chk(pins, 8'hb5, "mask");
      wr(A_INV, 8'hff);
      idle(3);
      chk(pins, 8'h4a, "mask inverted");
      wr(A_INV, 8'h00);
      $display("test mask done");
      wr(A_C1, 8'h80);
      wb(1'b0, A_C1, 8'h00, r);
      chk(r, 8'h80, "run readback");
      // flag written as 1 must not set
      wr(A_FD, 8'hea);
      wb(1'b0, A_FD, 8'h00, r);
      chk(r, 8'h6a, "flag write one");
      src_u.pulse(1'b1, 12);
      idle(4);
      chk({7'h00, run}, 8'h01, "pin disabled");
      wr(A_C2, 8'h08);
      idle(2);
      chk(ctl2, 8'h08, "control second");
      src_u.pulse(1'b1, 5);
      idle(6);
      chk({7'h00, run}, 8'h01, "short pulse");
      src_u.pulse(1'b1, 12);
      idle(4);
      chk({7'h00, run}, 8'h00, "run cleared");
      gen_wave <= 8'h00;
      idle(3);
      chk(pins, 8'haa, "brake pins");
      chk(8'(n_clr), 8'h01, "counter clear");
      chk({7'h00, irq}, 8'h01, "flag");
      wb(1'b0, A_FD, 8'h00, r);
      chk(r, 8'hea, "flag readback");
      wr(A_FD, 8'h6a);
      idle(3);
      chk({7'h00, irq}, 8'h00, "flag cleared");
      chk(pins, 8'haa, "brake persists");
      wr(A_C1, 8'h80);
      idle(3);
      chk(pins, 8'h05, "released");
      chk({7'h00, run}, 8'h01, "run again");
      $display("test pin fault done");
      wr(A_C2, 8'h00);
      src_u.set_idle(1'b1);
      wr(A_FD, 8'h15);
      wr(A_C2, 8'h08);
      src_u.pulse(1'b0, 12);
      idle(4);
      chk({7'h00, run}, 8'h00, "falling edge");
      chk(pins, 8'h15, "falling pins");
      wr(A_INV, 8'hc0);
      idle(3);
      chk(pins, 8'hd5, "held channels by software");
      $display("test falling edge done");
      wr(A_C1, 8'h80);
      wr(A_INV, 8'hff);
      gen_wave <= 8'hc0;
      idle(3);
      chk(pins, 8'h3a, "before adc");
      adc_evt <= 1'b1;
      @(posedge ref_clk_i);
      adc_evt <= 1'b0;
      idle(4);
      chk({7'h00, run}, 8'h00, "adc run");
      chk(pins, 8'h2a, "adc pins inverted");
      chk(8'(n_clr), 8'h03, "adc counter clear");
      $display("test adc fault done");
      give_verdict();
   end
endmodule : tb_pwm_output_mask_fault_polarity

`default_nettype wire
